// ### hw/plc_pkg.sv
// ----------------------------------------
// loop control constants
// ----------------------------------------
package plc_pkg;

   // register bus shape
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 8;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [1:0] OFS_LOOP_CTRL  = 2'h0;
   localparam logic [1:0] OFS_LOOP_BW    = 2'h1;
   localparam logic [1:0] OFS_BREAK_CTRL = 2'h2;

   // loop_control_register fields
   localparam int unsigned CTL_IRQ_EN_BIT = 7;
   localparam int unsigned CTL_FLAG_BIT   = 6;
   localparam int unsigned CTL_PWR_BIT    = 5;
   localparam int unsigned CTL_BCS_BIT    = 4;
   localparam logic [3:0]  CTL_UNUSED_VAL = 4'hF;

   // loop_bandwidth_register fields
   localparam int unsigned BW_AUTO_BIT    = 7;
   localparam int unsigned BW_LOCK_BIT    = 6;
   localparam int unsigned BW_TRK_BIT     = 5;

   // break_flag_control_register fields
   localparam int unsigned BRK_CLR_EN_BIT = 7;

   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic RST_IRQ_EN    = 1'b0;
   localparam logic RST_FLAG      = 1'b0;
   localparam logic RST_PWR       = 1'b1;
   localparam logic RST_BCS       = 1'b0;
   localparam logic RST_AUTO      = 1'b0;
   localparam logic RST_MAN_TRK   = 1'b0;
   localparam logic RST_CLR_EN    = 1'b0;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // synchroniser depth for pin inputs
   localparam int unsigned SYNC_STAGES = 3;

   // operating modes of the clock generator
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_WAIT,
      MODE_STOP
   } plc_mode_e;

endpackage

// ### hw/plc_sync_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// synchronised loop status
// ----------------------------------------
interface plc_sync_if;
   logic lock_level;    // filtered lock indicator
   logic lock_change;   // one-cycle pulse on any lock edge
   logic trk_level;     // filtered tracking indicator

   modport src (output lock_level, output lock_change, output trk_level);
   modport dst (input lock_level, input lock_change, input trk_level);
endinterface

// ### hw/plc_lock_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// lock and tracking status synchroniser
// ----------------------------------------
module plc_lock_sync (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  nrst,
   // raw analog status
   input  wire logic  lock_raw,
   input  wire logic  trk_raw,
   // filtered status
   plc_sync_if.src    sync
);

   logic [2:0] lock_ff_r, lock_ff_nxt;
   logic [2:0] trk_ff_r,  trk_ff_nxt;
   logic       lock_r,    lock_nxt;
   logic       trk_r,     trk_nxt;
   logic       chg_r,     chg_nxt;

   // shift chains; stage 0 is read only by stage 1
   always_comb begin
      lock_ff_nxt = {lock_ff_r[1:0], lock_raw};
      trk_ff_nxt  = {trk_ff_r[1:0], trk_raw};
      lock_nxt    = lock_r;
      trk_nxt     = trk_r;
      chg_nxt     = 1'b0;
      if (lock_ff_r[1] == lock_ff_r[2] && lock_ff_r[2] != lock_r) begin
         lock_nxt = lock_ff_r[2];
         chg_nxt  = 1'b1;
      end
      if (trk_ff_r[1] == trk_ff_r[2]) begin
         trk_nxt = trk_ff_r[2];
      end
   end

   // registers only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lock_ff_r <= 3'h0;
         trk_ff_r  <= 3'h0;
         lock_r    <= 1'b0;
         trk_r     <= 1'b0;
         chg_r     <= 1'b0;
      end else begin
         lock_ff_r <= lock_ff_nxt;
         trk_ff_r  <= trk_ff_nxt;
         lock_r    <= lock_nxt;
         trk_r     <= trk_nxt;
         chg_r     <= chg_nxt;
      end
   end

   assign sync.lock_level  = lock_r;
   assign sync.lock_change = chg_r;
   assign sync.trk_level   = trk_r;

endmodule

// ### hw/plc_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// loop lock event and low-power control
// ----------------------------------------

module plc_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // register port
   input  wire logic [1:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rdata,
   // loop status from analog side
   input  wire logic        lock_raw,
   input  wire logic        trk_raw,
   // cpu state
   input  wire logic        wait_req,
   input  wire logic        stop_req,
   input  wire logic        break_state,
   // clock controls and interrupt
   output logic             loop_interrupt_output,
   output logic             crystal_clock_output_en,
   output logic             base_clock_output_en,
   output logic             base_from_loop,
   output logic             loop_power_on_out,
   output logic             auto_mode_out
);

   // ----------------------------------------
   // status synchroniser
   // ----------------------------------------
   plc_sync_if sync_bus ();

   plc_lock_sync u_sync (
      .clk      (clk),
      .nrst     (nrst),
      .lock_raw (lock_raw),
      .trk_raw  (trk_raw),
      .sync     (sync_bus.src)
   );

   // ----------------------------------------
   // state declarations
   // ----------------------------------------
   logic                irq_en_r,  irq_en_nxt;
   logic                flag_r,    flag_nxt;
   logic                pwr_r,     pwr_nxt;
   logic                bcs_r,     bcs_nxt;
   logic                auto_r,    auto_nxt;
   logic                man_trk_r, man_trk_nxt;
   logic                clr_en_r,  clr_en_nxt;
   plc_pkg::plc_mode_e  mode_r,    mode_nxt;
   logic [7:0]          rdata_r,   rdata_nxt;
   logic                irq_r,     irq_nxt;
   logic                xen_r,     xen_nxt;
   logic                ben_r,     ben_nxt;

   // decoded strobes
   logic wr_ctl;
   logic wr_bw;
   logic wr_brk;
   logic rd_ctl;
   logic flag_prot;
   logic lock_vis;
   logic trk_vis;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // address match shared by read and write decode
   function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
      hit = (a == ofs);
   endfunction

   // register image of the control register
   function automatic logic [7:0] ctl_image(input logic ie, input logic fl,
                                             input logic pw, input logic bs);
      logic [7:0] v;
      v = {4'h0, plc_pkg::CTL_UNUSED_VAL};
      v[plc_pkg::CTL_IRQ_EN_BIT] = ie;
      v[plc_pkg::CTL_FLAG_BIT]   = fl;
      v[plc_pkg::CTL_PWR_BIT]    = pw;
      v[plc_pkg::CTL_BCS_BIT]    = bs;
      ctl_image = v;
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wr_ctl = wr_en && hit(addr, plc_pkg::OFS_LOOP_CTRL);
   assign wr_bw  = wr_en && hit(addr, plc_pkg::OFS_LOOP_BW);
   assign wr_brk = wr_en && hit(addr, plc_pkg::OFS_BREAK_CTRL);
   assign rd_ctl = rd_en && hit(addr, plc_pkg::OFS_LOOP_CTRL);

   // flag protected in break without enable
   assign flag_prot = break_state && !clr_en_r;

   // lock indicator meaningful only in auto
   assign lock_vis = auto_r && sync_bus.lock_level;
   assign trk_vis  = auto_r && sync_bus.trk_level;

   // ----------------------------------------
   // mode tracking
   // ----------------------------------------
   // stop dominates wait; both are levels from the cpu core
   always_comb begin
      if (stop_req) begin
         mode_nxt = plc_pkg::MODE_STOP;
      end else if (wait_req) begin
         mode_nxt = plc_pkg::MODE_WAIT;
      end else begin
         mode_nxt = plc_pkg::MODE_RUN;
      end
   end

   // ----------------------------------------
   // control and status bits
   // ----------------------------------------
   always_comb begin
      irq_en_nxt  = irq_en_r;
      flag_nxt    = flag_r;
      pwr_nxt     = pwr_r;
      bcs_nxt     = bcs_r;
      auto_nxt    = auto_r;
      man_trk_nxt = man_trk_r;
      clr_en_nxt  = clr_en_r;

      // control register write
      if (wr_ctl) begin
         // irq enable ignores writes and is held clear while in manual mode
         if (auto_r) begin
            irq_en_nxt = wdata[plc_pkg::CTL_IRQ_EN_BIT];
         end
         // power cannot drop while the loop feeds the base clock
         if (!(bcs_r && !wdata[plc_pkg::CTL_PWR_BIT])) begin
            pwr_nxt = wdata[plc_pkg::CTL_PWR_BIT];
         end
         if (pwr_r || !wdata[plc_pkg::CTL_BCS_BIT]) begin
            bcs_nxt = wdata[plc_pkg::CTL_BCS_BIT];
         end
      end

      // bandwidth register write; lock is read-only, tracking is written only in manual mode
      if (wr_bw) begin
         auto_nxt = wdata[plc_pkg::BW_AUTO_BIT];
         // manual tracking value kept aside while in auto
         if (!auto_r) begin
            man_trk_nxt = wdata[plc_pkg::BW_TRK_BIT];
         end
      end

      if (wr_brk) begin
         clr_en_nxt = wdata[plc_pkg::BRK_CLR_EN_BIT];
      end

      // clear in break sticks when enabled
      if (rd_ctl && !flag_prot) begin
         flag_nxt = 1'b0;
      end
      // any lock edge in auto mode
      // set one cycle after detected edge
      // set placed after the read clear so it wins over a same-cycle clear
      if (auto_r && sync_bus.lock_change) begin
         flag_nxt = 1'b1;
      end
      // flag held clear in manual mode
      if (!auto_r) begin
         flag_nxt   = 1'b0;
         irq_en_nxt = 1'b0;
      end

      // stop drops the loop as base source
      if (mode_r == plc_pkg::MODE_STOP || stop_req) begin
         bcs_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   // unmapped offsets read as zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_en) begin
         unique case (addr)
            plc_pkg::OFS_LOOP_CTRL: begin
               rdata_nxt = ctl_image(irq_en_r, flag_r, pwr_r, bcs_r);
            end
            plc_pkg::OFS_LOOP_BW: begin
               rdata_nxt[plc_pkg::BW_AUTO_BIT] = auto_r;
               rdata_nxt[plc_pkg::BW_LOCK_BIT] = lock_vis;
               rdata_nxt[plc_pkg::BW_TRK_BIT]  = auto_r ? trk_vis : man_trk_r;
            end
            plc_pkg::OFS_BREAK_CTRL: begin
               rdata_nxt[plc_pkg::BRK_CLR_EN_BIT] = clr_en_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------
   // clock gates and interrupt
   // ----------------------------------------
   // outputs are registered, so stop takes effect one cycle late;
   // the cpu has already halted by then, so nothing is lost
   always_comb begin
      xen_nxt = 1'b1;
      ben_nxt = 1'b1;
      irq_nxt = flag_nxt && irq_en_nxt;
      if (stop_req) begin
         xen_nxt = 1'b0;
         ben_nxt = 1'b0;
         irq_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_en_r  <= plc_pkg::RST_IRQ_EN;
         flag_r    <= plc_pkg::RST_FLAG;
         pwr_r     <= plc_pkg::RST_PWR;
         bcs_r     <= plc_pkg::RST_BCS;
         auto_r    <= plc_pkg::RST_AUTO;
         man_trk_r <= plc_pkg::RST_MAN_TRK;
         clr_en_r  <= plc_pkg::RST_CLR_EN;
         mode_r    <= plc_pkg::MODE_RUN;
         rdata_r   <= plc_pkg::RST_RDATA;
         irq_r     <= 1'b0;
         xen_r     <= 1'b1;
         ben_r     <= 1'b1;
      end else begin
         irq_en_r  <= irq_en_nxt;
         flag_r    <= flag_nxt;
         pwr_r     <= pwr_nxt;
         bcs_r     <= bcs_nxt;
         auto_r    <= auto_nxt;
         man_trk_r <= man_trk_nxt;
         clr_en_r  <= clr_en_nxt;
         mode_r    <= mode_nxt;
         rdata_r   <= rdata_nxt;
         irq_r     <= irq_nxt;
         xen_r     <= xen_nxt;
         ben_r     <= ben_nxt;
      end
   end

   // ----------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------
   assign rdata                   = rdata_r;
   assign loop_interrupt_output   = irq_r;
   assign crystal_clock_output_en = xen_r;
   assign base_clock_output_en    = ben_r;
   assign base_from_loop          = bcs_r;
   assign loop_power_on_out       = pwr_r;
   assign auto_mode_out           = auto_r;

endmodule

// ### verif/plc_top_asserts.sv
`timescale 1ns/1ps
module plc_top_asserts (
   // clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // register port
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   // status and cpu state
   input wire logic       lock_raw,
   input wire logic       wait_req,
   input wire logic       stop_req,
   input wire logic       break_state,
   // outputs
   input wire logic       loop_interrupt_output,
   input wire logic       crystal_clock_output_en,
   input wire logic       base_clock_output_en,
   input wire logic       base_from_loop,
   input wire logic       loop_power_on_out,
   input wire logic       auto_mode_out
);
   logic       lock_q_r;
   logic       lock_q_nxt;
   logic [3:0] quiet_r;
   logic [3:0] quiet_nxt;
   logic       ctl_a;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   assign ctl_a = (addr == plc_pkg::OFS_LOOP_CTRL);

   // ----------------------------------------
   // cycles since the raw lock last moved
   // ----------------------------------------
   // saturates so a long quiet spell never wraps
   always_comb begin
      lock_q_nxt = lock_raw;
      quiet_nxt  = (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
      if (lock_raw != lock_q_r) begin
         quiet_nxt = 4'h0;
      end
   end

   // registers only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lock_q_r <= 1'b0;
         quiet_r  <= 4'h0;
      end else begin
         lock_q_r <= lock_q_nxt;
         quiet_r  <= quiet_nxt;
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_irq_stop;
      stop_req |=> !loop_interrupt_output;
   endproperty
   a_irq_stop: assert property (p_irq_stop)
      else $error("irq high in stop");

   property p_clk_stop;
      stop_req |=> !crystal_clock_output_en && !base_clock_output_en;
   endproperty
   a_clk_stop: assert property (p_clk_stop)
      else $error("clock gate open in stop");

   property p_bcs_stop;
      stop_req |=> !base_from_loop;
   endproperty
   a_bcs_stop: assert property (p_bcs_stop)
      else $error("loop select kept in stop");

   property p_bcs_resume;
      $fell(stop_req) && !wr_en |=> !base_from_loop && base_clock_output_en;
   endproperty
   a_bcs_resume: assert property (p_bcs_resume)
      else $error("bad resume from stop");

   property p_bcs_pwr;
      wr_en && ctl_a && wdata[4] && !loop_power_on_out && !base_from_loop |=> !base_from_loop;
   endproperty
   a_bcs_pwr: assert property (p_bcs_pwr)
      else $error("loop select taken with loop off");

   property p_irq_manual;
      (!auto_mode_out) [*2] |-> !loop_interrupt_output;
   endproperty
   a_irq_manual: assert property (p_irq_manual)
      else $error("irq in manual mode");

   property p_flag_clr;
      rd_en && ctl_a && !break_state && quiet_r >= 4'h8 |=> !loop_interrupt_output;
   endproperty
   a_flag_clr: assert property (p_flag_clr)
      else $error("control read left irq up");

   property p_wait;
      wait_req && !stop_req |=> crystal_clock_output_en && base_clock_output_en;
   endproperty
   a_wait: assert property (p_wait)
      else $error("clock gated in wait");
endmodule

bind plc_top plc_top_asserts u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .lock_raw(lock_raw), .wait_req(wait_req), .stop_req(stop_req),
   .break_state(break_state), .loop_interrupt_output(loop_interrupt_output),
   .crystal_clock_output_en(crystal_clock_output_en), .base_clock_output_en(base_clock_output_en),
   .base_from_loop(base_from_loop), .loop_power_on_out(loop_power_on_out), .auto_mode_out(auto_mode_out));

// ### verif/plc_loop_model.sv
`timescale 1ns/1ps
module plc_loop_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // loop power and target
   input  wire logic pwr,
   input  wire logic lock_go,
   // analog status
   output logic      lock_raw,
   output logic      trk_raw
);
   logic [2:0] cnt_r;

   // settles some cycles after power and target; drops at once
   // tracking then lock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 3'h0;
      end else if (pwr && lock_go) begin
         cnt_r <= (cnt_r == 3'h6) ? cnt_r : cnt_r + 3'h1;
      end else begin
         cnt_r <= 3'h0;
      end
   end

   assign trk_raw  = (cnt_r >= 3'h3);
   assign lock_raw = (cnt_r == 3'h6);
endmodule

// ### verif/plc_top_tb.sv
`timescale 1ns/1ps
module plc_top_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam logic [1:0] CT = plc_pkg::OFS_LOOP_CTRL;
   localparam logic [1:0] BW = plc_pkg::OFS_LOOP_BW;
   localparam logic [1:0] BK = plc_pkg::OFS_BREAK_CTRL;
   logic       clk, nrst, wr_en, rd_en, lock_raw, trk_raw;
   logic       wait_req, stop_req, break_state, lock_go;
   logic       irq, xen, ben, bfl, pwr, aut;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, d;
   int         n_fail, samples_checked, cyc;

   plc_top DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .lock_raw(lock_raw), .trk_raw(trk_raw), .wait_req(wait_req), .stop_req(stop_req),
      .break_state(break_state), .loop_interrupt_output(irq), .crystal_clock_output_en(xen),
      .base_clock_output_en(ben), .base_from_loop(bfl), .loop_power_on_out(pwr), .auto_mode_out(aut));

   plc_loop_model LM (.clk(clk), .nrst(nrst), .pwr(pwr), .lock_go(lock_go), .lock_raw(lock_raw),
      .trk_raw(trk_raw));

   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rc(input string n, input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
      chk(n, e, d);
   endtask

   // move the loop target, then let sync and flag settle
   task automatic lk(input logic v);
      @(posedge clk) lock_go <= v;
      repeat (20) @(posedge clk);
      #1;
   endtask

   task automatic conclude();
      $display("checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // clock and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // the tests need under 1000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         conclude();
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {nrst, wr_en, rd_en, wait_req, stop_req, break_state, lock_go} = 7'h00;
      addr = 2'h0;
      wdata = 8'h00;
      n_fail = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rc("ctrl", CT, 8'h2F);
      rc("bw", BW, 8'h00);
      rc("unmapped", 2'h3, 8'h00);
      chk("auto", 8'h00, {7'h00, aut});
      lk(1'b1);
      rc("ctrl", CT, 8'h2F);
      chk("irq", 8'h00, {7'h00, irq});
      lk(1'b0);
      $display("test reset and manual done");
      wr(BW, 8'h80);
      chk("auto", 8'h01, {7'h00, aut});
      wr(CT, 8'hA0);
      // raw lock edge to interrupt takes five clock edges
      @(posedge clk) lock_go <= 1'b1;
      @(posedge lock_raw);
      repeat (4) @(posedge clk);
      #1;
      chk("irq early", 8'h00, {7'h00, irq});
      @(posedge clk);
      #1;
      chk("irq", 8'h01, {7'h00, irq});
      rc("bw", BW, 8'hE0);
      rc("ctrl", CT, 8'hEF);
      rc("ctrl", CT, 8'hAF);
      chk("irq", 8'h00, {7'h00, irq});
      wr(CT, 8'h20);
      lk(1'b0);
      chk("irq", 8'h00, {7'h00, irq});
      rc("ctrl", CT, 8'h6F);
      $display("test events done");
      lk(1'b1);
      @(posedge clk) break_state <= 1'b1;
      rc("ctrl", CT, 8'h6F);
      wr(CT, 8'h20);
      rc("ctrl", CT, 8'h6F);
      wr(BK, 8'h80);
      rc("ctrl", CT, 8'h6F);
      rc("ctrl", CT, 8'h2F);
      @(posedge clk) break_state <= 1'b0;
      wr(BK, 8'h00);
      rc("ctrl", CT, 8'h2F);
      $display("test break done");
      lk(1'b0);
      wr(CT, 8'h30);
      chk("sel", 8'h01, {7'h00, bfl});
      wr(CT, 8'h00);
      chk("sel pwr", 8'h01, {6'h00, bfl, pwr});
      wr(CT, 8'h00);
      wr(CT, 8'h10);
      chk("sel pwr", 8'h00, {6'h00, bfl, pwr});
      wr(CT, 8'h30);
      chk("sel pwr", 8'h01, {6'h00, bfl, pwr});
      $display("test select done");
      wr(CT, 8'hA0);
      lk(1'b1);
      // confirm lock before taking the loop as base source
      rc("lock", BW, 8'hE0);
      wr(CT, 8'hB0);
      chk("sel irq", 8'h03, {6'h00, bfl, irq});
      @(posedge clk) wait_req <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("wait", 8'h0F, {4'h0, xen, ben, bfl, irq});
      @(posedge clk) wait_req <= 1'b0;
      @(posedge clk) stop_req <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("stop", 8'h00, {4'h0, xen, ben, bfl, irq});
      @(posedge clk) stop_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("resume", 8'h0C, {4'h0, xen, ben, bfl, 1'b0});
      // loop switched off before wait; clocks keep running
      wr(CT, 8'h80);
      @(posedge clk) wait_req <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("wait off", 8'h0C, {4'h0, xen, ben, bfl, pwr});
      @(posedge clk) wait_req <= 1'b0;
      $display("test low power done");
      conclude();
   end
endmodule
